//--- src/eii_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "eii_cfg.svh"
// Behaviour
// - Four independent external interrupt inputs 0..3, each able to wake from power-down.
// - Selected pin with configured level or edge sets flag and raises controller request.
// - Level mode: flag sets while function selected and pin at active level.
// - Edge mode: flag sets when configured edge seen on selected pin.
// - Writing one clears flag; in level mode only while pin inactive.
// - Flags map to inputs 0..3, reset zero; bits 7:4 reserved.
// - Wake-enable bits 0..3 let asserted input wake processor; reset zero.
// - Wake only when the input function is mapped to some pin.
// - Wake is independent of interrupt controller enable.
// - Bit 14 enables brown-out wake, bit 15 enables clock alarm wake.
// - Mode bit 0 selects level, 1 selects edge; resets to 0.
// - Polarity 0 low/falling, 1 high/rising; resets to 0.
// - Inputs 0..2 take two candidate pins, input 3 takes three.
// - Low-active level: selected pin states combined with AND.
// - High-active level: selected pin states combined with OR.
// - Edge mode uses only lowest-numbered selected pin.
// - Only selected pins with controller enable produce interrupts.
// - Power-down entry refused while a flag that caused a wake stays set.
module eii_top #(
  parameter int NPIN = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [NPIN-1:0] pin_state_0,
  input wire logic [NPIN-1:0] pin_state_1,
  input wire logic [NPIN-1:0] pin_state_2,
  input wire logic [NPIN-1:0] pin_state_3,
  input wire logic [NPIN-1:0] pin_sel_0,
  input wire logic [NPIN-1:0] pin_sel_1,
  input wire logic [NPIN-1:0] pin_sel_2,
  input wire logic [NPIN-1:0] pin_sel_3,
  input wire logic [3:0] irq_ctrl_enable,
  input wire logic brownout_irq,
  input wire logic clock_alarm_irq,
  input wire logic power_down_active,
  output logic [3:0] irq_req,
  output logic wake_req,
  output logic power_down_enter
);
  import eii_pkg::*;

  // Input 0..2 use only candidates 0 and 1; candidate 2 is ignored for them.
  localparam logic [2:0] CAND_MASK_LO = 3'h3;
  localparam logic [2:0] CAND_MASK_HI = 3'h7;

  logic [3:0] flags_reg;
  logic [15:0] wake_reg;
  logic [3:0] sense_reg;
  logic [3:0] pol_reg;
  logic [3:0] woke_reg;
  logic [3:0] prev_reg;
  logic [NPIN-1:0] sync1_reg [4];
  logic [NPIN-1:0] sync2_reg [4];
  logic [NPIN-1:0] sel_reg [4];
  logic [3:0] sig_next;
  logic [3:0] any_sel;
  logic [3:0] active_lvl;
  logic [3:0] edge_hit;
  logic [3:0] set_next;
  logic [3:0] clr_req;
  logic pd_req;
  eii_bus_t bus_reg;

  logic [NPIN-1:0] sel1_reg [4];
  logic [3:0] sig_and;
  logic [3:0] sig_or;
  logic [3:0] sig_edge;

  logic wr_accept;
  logic wr_flags;
  logic wr_wake;
  logic wr_mode;
  logic wr_pol;
  logic rd_mapped;
  logic [31:0] rd_word;

  logic [3:0] wake_src;
  logic wake_any;
  logic pd_block;

  function automatic logic lowest_sel(input logic [NPIN-1:0] st, input logic [NPIN-1:0] sl);
    logic r;
    logic found;
    r = 1'b0;
    found = 1'b0;
    for (int i = 0; i < NPIN; i++) begin
      if (sl[i] && !found) begin
        r = st[i];
        found = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [NPIN-1:0] cand_mask(input int n);
    logic [NPIN-1:0] m;
    m = '0;
    for (int i = 0; i < NPIN; i++) begin
      m[i] = (n == 3) ? CAND_MASK_HI[i] : CAND_MASK_LO[i];
    end
    return m;
  endfunction

  // Full address decode; aliases inside the block are answered as unmapped.
  function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] ofs);
    return addr == ofs;
  endfunction

  // Narrow registers read back in the low bits with zeros above.
  function automatic logic [31:0] pad_nib(input logic [3:0] v);
    return {28'h0, v};
  endfunction

  // Pin levels pass two flip-flops before any use.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int n = 0; n < 4; n++) begin
        sync1_reg[n] <= '0;
      end
    end else begin
      sync1_reg[0] <= pin_state_0;
      sync1_reg[1] <= pin_state_1;
      sync1_reg[2] <= pin_state_2;
      sync1_reg[3] <= pin_state_3;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int n = 0; n < 4; n++) begin
        sync2_reg[n] <= '0;
      end
    end else begin
      for (int n = 0; n < 4; n++) begin
        sync2_reg[n] <= sync1_reg[n];
      end
    end
  end

  // The selection takes the same two stages, so a pin and its select change together.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int n = 0; n < 4; n++) begin
        sel1_reg[n] <= '0;
      end
    end else begin
      sel1_reg[0] <= pin_sel_0 & cand_mask(0);
      sel1_reg[1] <= pin_sel_1 & cand_mask(1);
      sel1_reg[2] <= pin_sel_2 & cand_mask(2);
      sel1_reg[3] <= pin_sel_3 & cand_mask(3);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int n = 0; n < 4; n++) begin
        sel_reg[n] <= '0;
      end
    end else begin
      for (int n = 0; n < 4; n++) begin
        sel_reg[n] <= sel1_reg[n];
      end
    end
  end

  // Each input's pins are merged per mode before any level or edge test.
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      any_sel[n] = |sel_reg[n];
      sig_and[n] = &(sync2_reg[n] | ~sel_reg[n]);
      sig_or[n] = |(sync2_reg[n] & sel_reg[n]);
      sig_edge[n] = lowest_sel(sync2_reg[n], sel_reg[n]);
      case ({sense_reg[n], pol_reg[n]})
        2'b00: begin
          sig_next[n] = sig_and[n];
        end
        2'b01: begin
          sig_next[n] = sig_or[n];
        end
        default: begin
          sig_next[n] = sig_edge[n];
        end
      endcase
    end
  end

  always_comb begin
    for (int n = 0; n < 4; n++) begin
      active_lvl[n] = any_sel[n] && (sig_next[n] == pol_reg[n]);
      edge_hit[n] = any_sel[n] && (sig_next[n] != prev_reg[n]) &&
                    (sig_next[n] == pol_reg[n]);
      set_next[n] = sense_reg[n] ? edge_hit[n] : active_lvl[n];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prev_reg <= 4'h0;
    end else begin
      prev_reg <= sig_next;
    end
  end

  // A write takes effect at the edge where the master samples waitrequest low.
  assign wr_accept = avs_write && !avs_waitrequest && bus_reg == EII_DONE;
  assign wr_flags = wr_accept && reg_hit(avs_address, `EII_OFS_FLAGS) && avs_byteenable[0];
  assign wr_wake = wr_accept && reg_hit(avs_address, `EII_OFS_WAKE);
  assign wr_mode = wr_accept && reg_hit(avs_address, `EII_OFS_MODE) && avs_byteenable[0];
  assign wr_pol = wr_accept && reg_hit(avs_address, `EII_OFS_POL) && avs_byteenable[0];
  assign pd_req = wr_accept && reg_hit(avs_address, `EII_OFS_PDREQ) && avs_byteenable[0] &&
                  avs_writedata[0];

  always_comb begin
    clr_req = 4'h0;
    if (wr_flags) begin
      clr_req = avs_writedata[3:0];
    end
  end

  // A set in the same cycle as a clear wins; level clears are blocked while active.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flags_reg <= `EII_RST_FLAGS;
    end else begin
      for (int n = 0; n < 4; n++) begin
        if (set_next[n]) begin
          flags_reg[n] <= 1'b1;
        end else if (clr_req[n]) begin
          flags_reg[n] <= 1'b0;
        end
      end
    end
  end

  // Wake sources are gathered apart from the controller enables.
  always_comb begin
    wake_src = flags_reg & wake_reg[3:0] & any_sel;
    wake_any = |wake_src || (brownout_irq && wake_reg[`EII_BIT_BOD_WAKE]) ||
               (clock_alarm_irq && wake_reg[`EII_BIT_RTC_WAKE]);
  end

  assign pd_block = woke_reg != 4'h0;

  // Remembers which flags woke the processor, for power-down refusal.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      woke_reg <= 4'h0;
    end else begin
      woke_reg <= (woke_reg & flags_reg) | (power_down_active ? wake_src : 4'h0);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wake_reg <= `EII_RST_WAKE;
    end else if (wr_wake) begin
      if (avs_byteenable[0]) begin
        wake_reg[3:0] <= avs_writedata[3:0];
      end
      if (avs_byteenable[1]) begin
        wake_reg[15:14] <= avs_writedata[15:14];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sense_reg <= `EII_RST_MODE;
    end else if (wr_mode) begin
      sense_reg <= avs_writedata[3:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pol_reg <= `EII_RST_POL;
    end else if (wr_pol) begin
      pol_reg <= avs_writedata[3:0];
    end
  end

  // Request toward the controller follows the flag, the enable and the pin selection.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_req <= 4'h0;
    end else begin
      irq_req <= flags_reg & irq_ctrl_enable & any_sel;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= wake_any;
    end
  end

  // Entry is a one-cycle pulse, held back while a flag that woke the processor is set.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      power_down_enter <= 1'b0;
    end else if (pd_req && !pd_block) begin
      power_down_enter <= 1'b1;
    end else begin
      power_down_enter <= 1'b0;
    end
  end

  // Read data for the addressed register; an unmapped address reads as zero.
  always_comb begin
    rd_mapped = 1'b1;
    rd_word = 32'h0;
    case (avs_address)
      `EII_OFS_FLAGS: rd_word = pad_nib(flags_reg);
      `EII_OFS_WAKE: rd_word = {16'h0, wake_reg[15:14], 10'h0, wake_reg[3:0]};
      `EII_OFS_MODE: rd_word = pad_nib(sense_reg);
      `EII_OFS_POL: rd_word = pad_nib(pol_reg);
      `EII_OFS_PDREQ: rd_word = {31'h0, pd_block};
      default: rd_mapped = 1'b0;
    endcase
  end

  // Avalon slave: every access takes one wait cycle and is answered on the next edge.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_reg <= EII_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      avs_response <= 2'h0;
    end else begin
      case (bus_reg)
        EII_IDLE: begin
          if (avs_read || avs_write) begin
            bus_reg <= EII_DONE;
            avs_waitrequest <= 1'b0;
            avs_readdata <= rd_word;
            avs_response <= rd_mapped ? 2'h0 : 2'h3;
          end
        end
        EII_DONE: begin
          bus_reg <= EII_IDLE;
          avs_waitrequest <= 1'b1;
          avs_response <= 2'h0;
        end
        default: begin
          bus_reg <= EII_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- src/eii_cfg.svh
`ifndef EII_CFG_SVH
`define EII_CFG_SVH
`define EII_OFS_FLAGS 32'hE01FC140
`define EII_OFS_WAKE 32'hE01FC144
`define EII_OFS_MODE 32'hE01FC148
`define EII_OFS_POL 32'hE01FC14C
`define EII_OFS_PDREQ 32'hE01FC150
`define EII_BIT_BOD_WAKE 14
`define EII_BIT_RTC_WAKE 15
`define EII_RST_FLAGS 4'h0
`define EII_RST_WAKE 16'h0000
`define EII_RST_MODE 4'h0
`define EII_RST_POL 4'h0
`endif

//--- src/eii_pkg.sv
package eii_pkg;
  typedef enum logic [1:0] {
    EII_IDLE = 2'b00,
    EII_DONE = 2'b01
  } eii_bus_t;
  typedef logic [3:0] eii_nib_t;
endpackage

//--- verification/eii_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "eii_cfg.svh"
module eii_top_asserts #(
  parameter int NPIN = 3
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [31:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  input wire logic [NPIN-1:0] pin_sel_0,
  input wire logic [NPIN-1:0] pin_sel_3,
  input wire logic [3:0] irq_ctrl_enable,
  input wire logic [3:0] irq_req,
  input wire logic power_down_enter
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  function automatic logic mapped(logic [31:0] a);
    return a inside {`EII_OFS_FLAGS, `EII_OFS_WAKE, `EII_OFS_MODE, `EII_OFS_POL, `EII_OFS_PDREQ};
  endfunction
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_answer_next: assert property (s_taken |=> s_answer)
    else $error("bus answer not one cycle after request");
  chk_resp_decode: assert property (!avs_waitrequest |->
    avs_response == (mapped($past(avs_address)) ? 2'h0 : 2'h3))
    else $error("response code does not match address decode");
  chk_bad_rdata: assert property (!avs_waitrequest && avs_response == 2'h3 |-> avs_readdata == 32'h0)
    else $error("unmapped read returned data");
  chk_resv_zero: assert property (!avs_waitrequest && $past(avs_read) |-> avs_readdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  chk_irq_gate0: assert property (irq_req[0] |-> $past(irq_ctrl_enable[0]) && $past(pin_sel_0[1:0], 3) != 2'h0)
    else $error("request 0 without enable or pin");
  chk_irq_gate3: assert property (irq_req[3] |-> $past(irq_ctrl_enable[3]) && $past(pin_sel_3, 3) != 0)
    else $error("request 3 without enable or pin");
  chk_pd_pulse: assert property (power_down_enter |=> !power_down_enter)
    else $error("power-down entry longer than one cycle");
  chk_pd_cause: assert property ($rose(power_down_enter) |-> $past(avs_write) || $past(avs_write, 2))
    else $error("power-down entry without a write");
endmodule
bind eii_top eii_top_asserts #(.NPIN(NPIN)) u_chk (.mclk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .avs_response, .pin_sel_0, .pin_sel_3, .irq_ctrl_enable,
  .irq_req, .power_down_enter);
`default_nettype wire

//--- verification/eii_pins.sv
`timescale 1ns/1ps
`default_nettype none
module eii_pins #(
  parameter int NPIN = 3
) (
  input wire logic mclk,
  output logic [NPIN-1:0] pin_state_0,
  output logic [NPIN-1:0] pin_state_1,
  output logic [NPIN-1:0] pin_state_2,
  output logic [NPIN-1:0] pin_state_3,
  output logic [NPIN-1:0] pin_sel_0,
  output logic [NPIN-1:0] pin_sel_1,
  output logic [NPIN-1:0] pin_sel_2,
  output logic [NPIN-1:0] pin_sel_3
);
  logic [NPIN-1:0] lvl [4];
  logic [NPIN-1:0] sel [4];
  logic noise;
  initial begin
    lvl = '{default: '1};
    sel = '{default: '0};
    noise = 1'b0;
  end
  always @(posedge mclk) noise <= ~noise;
  // Unselected pins toggle every cycle so that any leak into the combine logic shows.
  assign pin_state_0 = (lvl[0] & sel[0]) | ({NPIN{noise}} & ~sel[0]);
  assign pin_state_1 = (lvl[1] & sel[1]) | ({NPIN{noise}} & ~sel[1]);
  assign pin_state_2 = (lvl[2] & sel[2]) | ({NPIN{noise}} & ~sel[2]);
  assign pin_state_3 = (lvl[3] & sel[3]) | ({NPIN{noise}} & ~sel[3]);
  assign pin_sel_0 = sel[0];
  assign pin_sel_1 = sel[1];
  assign pin_sel_2 = sel[2];
  assign pin_sel_3 = sel[3];
  task automatic drive(int n, logic [NPIN-1:0] l, logic [NPIN-1:0] s);
    @(posedge mclk);
    lvl[n] <= l;
    sel[n] <= s;
  endtask
endmodule
`default_nettype wire

//--- verification/eii_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "eii_cfg.svh"
module eii_top_tb;
  logic mclk, rst, avs_read, avs_write, avs_waitrequest, brownout_irq, clock_alarm_irq;
  logic power_down_active, wake_req, power_down_enter;
  logic [31:0] avs_address, avs_writedata, avs_readdata, q;
  logic [1:0] avs_response, r;
  logic [3:0] irq_ctrl_enable, irq_req;
  logic [2:0] pin_state_0, pin_state_1, pin_state_2, pin_state_3;
  logic [2:0] pin_sel_0, pin_sel_1, pin_sel_2, pin_sel_3;
  int num_errors, compares, pd_cnt;
  eii_top DUT (.mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .avs_response, .pin_state_0,
    .pin_state_1, .pin_state_2, .pin_state_3, .pin_sel_0, .pin_sel_1, .pin_sel_2, .pin_sel_3,
    .irq_ctrl_enable, .brownout_irq, .clock_alarm_irq, .power_down_active, .irq_req,
    .wake_req, .power_down_enter);
  eii_pins PINS (.mclk, .pin_state_0, .pin_state_1, .pin_state_2, .pin_state_3, .pin_sel_0,
    .pin_sel_1, .pin_sel_2, .pin_sel_3);
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(posedge mclk) pd_cnt <= pd_cnt + int'(power_down_enter === 1'b1);
  task automatic give_verdict;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic bus(logic [31:0] a, logic wr, logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) chk("waitrequest", 0, 1);
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask
  task automatic pins(int n, logic [2:0] l, logic [2:0] s);
    PINS.drive(n, l, s);
    repeat (6) @(posedge mclk);
  endtask
  initial begin
    repeat (3000) @(posedge mclk);
    num_errors++;
    give_verdict();
  end
  initial begin
    {rst, avs_read, avs_write, brownout_irq, clock_alarm_irq, power_down_active} = 6'h20;
    {avs_address, avs_writedata, irq_ctrl_enable} = '0;
    {num_errors, compares, pd_cnt} = '0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(`EII_OFS_FLAGS + 4 * i, 32'h0);
    bus(`EII_OFS_MODE, 1'b1, 32'hFF);
    rd(`EII_OFS_MODE, 32'hF);
    bus(`EII_OFS_WAKE, 1'b1, 32'hFFFF);
    rd(`EII_OFS_WAKE, 32'hC00F);
    bus(32'hE01FC154, 1'b0, 32'h0);
    chk("resp", 3, r);
    bus(`EII_OFS_MODE, 1'b1, 32'h8);
    bus(`EII_OFS_POL, 1'b1, 32'hA);
    bus(`EII_OFS_WAKE, 1'b1, 32'h1);
    irq_ctrl_enable <= 4'h2;
    power_down_active <= 1'b1;
    pins(0, 3'b001, 3'b011);
    rd(`EII_OFS_FLAGS, 32'h1);
    chk("wake", 1, wake_req);
    chk("irq", 0, irq_req);
    power_down_active <= 1'b0;
    bus(`EII_OFS_FLAGS, 1'b1, 32'h1);
    rd(`EII_OFS_FLAGS, 32'h1);
    bus(`EII_OFS_PDREQ, 1'b1, 32'h1);
    repeat (3) @(posedge mclk);
    chk("pd", 0, pd_cnt);
    pins(0, 3'b011, 3'b011);
    bus(`EII_OFS_FLAGS, 1'b1, 32'h1);
    rd(`EII_OFS_FLAGS, 32'h0);
    bus(`EII_OFS_PDREQ, 1'b1, 32'h1);
    repeat (3) @(posedge mclk);
    chk("pd", 1, pd_cnt);
    pins(1, 3'b001, 3'b011);
    rd(`EII_OFS_FLAGS, 32'h2);
    chk("irq", 2, irq_req);
    pins(1, 3'b000, 3'b011);
    bus(`EII_OFS_FLAGS, 1'b1, 32'h2);
    irq_ctrl_enable <= 4'hA;
    pins(3, 3'b000, 3'b110);
    bus(`EII_OFS_FLAGS, 1'b1, 32'hF);
    pins(3, 3'b100, 3'b110);
    rd(`EII_OFS_FLAGS, 32'h0);
    pins(3, 3'b110, 3'b110);
    rd(`EII_OFS_FLAGS, 32'h8);
    chk("irq", 8, irq_req);
    bus(`EII_OFS_FLAGS, 1'b1, 32'h8);
    rd(`EII_OFS_FLAGS, 32'h0);
    power_down_active <= 1'b1;
    bus(`EII_OFS_WAKE, 1'b1, 32'h8000);
    brownout_irq <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("wake", 0, wake_req);
    clock_alarm_irq <= 1'b1;
    repeat (4) @(posedge mclk);
    chk("wake", 1, wake_req);
    give_verdict();
  end
endmodule
`default_nettype wire
